// File: rtl/pss_defines.svh
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// ----------------------------------------------------------------------
// Frequency encoding, 0.1 Hz per count
// ----------------------------------------------------------------------
`define PSS_SENTINEL 16'h270F
`define PSS_DEF_HIGH 16'h0258
`define PSS_DEF_MID 16'h012C
`define PSS_DEF_LOW 16'h0064
`define PSS_DEF_MAX 16'h04B0
`define PSS_DEF_ZERO 16'h0000
`define PSS_STEP 16'h0001

// ----------------------------------------------------------------------
// Preset slots: 0 high, 1 mid, 2 low, 3..14 speeds 4..15
// ----------------------------------------------------------------------
`define PSS_NPRE 15
`define PSS_IDX_HIGH 4'h0
`define PSS_IDX_MID 4'h1
`define PSS_IDX_LOW 4'h2
`define PSS_IDX_SPD4 4'h3
`define PSS_IDX_SPD5 4'h4
`define PSS_IDX_SPD6 4'h5
`define PSS_IDX_SPD7 4'h6
`define PSS_IDX_SPD8 4'h7

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PSS_A_PRESET_END 8'h38
`define PSS_A_MODE 8'h40
`define PSS_A_GUARD 8'h44
`define PSS_A_ASSIGN 8'h48
`define PSS_A_NET 8'h4C
`define PSS_A_PANEL 8'h50
`define PSS_A_MAX 8'h54
`define PSS_A_STATUS 8'h58
`define PSS_A_REMOTE 8'h5C
`define PSS_A_STORED 8'h60

// ----------------------------------------------------------------------
// Terminal function codes and modes
// ----------------------------------------------------------------------
`define PSS_NTERM 5
`define PSS_FN_LOW 4'h0
`define PSS_FN_MID 4'h1
`define PSS_FN_HIGH 4'h2
`define PSS_FN_EXT 4'h8
`define PSS_ASSIGN_RST 20'hFF210
`define PSS_MODE_PRESET 2'h0
`define PSS_MODE_STORE 2'h1
`define PSS_MODE_CLRRUN 2'h3

// ----------------------------------------------------------------------
// Synchronised pin vector positions
// ----------------------------------------------------------------------
`define PSS_P_FWD 5
`define PSS_P_REV 6
`define PSS_P_JOG 7
`define PSS_P_PID 8
`define PSS_P_EV 9
`define PSS_P_PANEL 10

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PSS_CLK_NS 25
`define PSS_MINUTE_S 60
`define PSS_STEP_US 1000

`endif

// File: rtl/pss_pkg.sv
package pss_pkg;

  // Bus handshake states, one bit changing per step except DONE back to IDLE.
  typedef enum logic [1:0]
  {
    PSS_BUS_IDLE = 2'h0,
    PSS_BUS_ACK = 2'h1,
    PSS_BUS_DONE = 2'h3
  } pss_bus_t;

  // Whole state of the top module.
  typedef struct packed
  {
    logic [10:0] sy1;
    logic [10:0] sy2;
    logic [14:0][15:0] pre;
    logic [1:0] mode;
    logic guard;
    logic [19:0] asg;
    logic [15:0] net;
    logic [15:0] panel;
    logic [15:0] maxf;
    logic [15:0] remote;
    logic [31:0] step;
    logic restore;
    logic run_d;
    logic ev_d;
    logic aux;
    logic [15:0] freq;
    pss_bus_t bus;
    logic wreq;
    logic [31:0] rdata;
  } pss_state_t;

  // Whole state of the storage scheduler.
  typedef struct packed
  {
    logic [31:0] cnt;
    logic [15:0] stored;
    logic wr;
    logic [15:0] wdata;
  } pss_nvs_t;

endpackage

// File: rtl/pss_nvm_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "pss_defines.svh"

module pss_nvm_store #(
  parameter logic [31:0] MINUTE_CYC = 32'h8F0D_1800
) (
  input wire logic clk_i, // Core clock.
  input wire logic reset_n_i, // Asynchronous reset, active low.
  input wire logic ce_i, // Clock enable.
  input wire logic enable_i, // Storage mode selected.
  input wire logic idle_i, // Accelerate and decelerate equal.
  input wire logic save_now_i, // Immediate save request.
  input wire logic load_i, // Take load_val_i as stored copy.
  input wire logic [15:0] load_val_i, // Value restored at power-up.
  input wire logic [15:0] value_i, // Current remote frequency.
  output logic nvm_wr_o, // One-cycle write strobe.
  output logic [15:0] nvm_wdata_o, // Data for the write.
  output logic [15:0] stored_o // Last value written.
);

  pss_pkg::pss_nvs_t s_r;
  pss_pkg::pss_nvs_t s_nxt;

  // --------------------------------------------------------------------
  // Save scheduling
  // --------------------------------------------------------------------
  // The minute check writes only on change to spare memory endurance.
  always_comb
  begin
    s_nxt = s_r;
    if (ce_i)
    begin
      s_nxt.wr = 1'b0;
      if (!idle_i || !enable_i)
        s_nxt.cnt = '0;
      else if (s_r.cnt == MINUTE_CYC - 32'h1)
        s_nxt.cnt = '0;
      else
        s_nxt.cnt = s_r.cnt + 32'h1;
      if (load_i)
        s_nxt.stored = load_val_i;
      else if (enable_i && save_now_i)
      begin
        s_nxt.wr = 1'b1;
        s_nxt.wdata = value_i;
        s_nxt.stored = value_i;
      end
      else if (enable_i && idle_i && s_r.cnt == MINUTE_CYC - 32'h1 &&
               value_i != s_r.stored)
      begin
        s_nxt.wr = 1'b1;
        s_nxt.wdata = value_i;
        s_nxt.stored = value_i;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign nvm_wr_o = s_r.wr;
  assign nvm_wdata_o = s_r.wdata;
  assign stored_o = s_r.stored;

  minute_save_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && enable_i && idle_i && !load_i && s_r.cnt == MINUTE_CYC - 32'h1
    && value_i != s_r.stored |=> nvm_wr_o && nvm_wdata_o == $past(value_i))
    else $error("minute compare did not write a changed value");

endmodule
`default_nettype wire

// File: rtl/pss_top.sv
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pss_defines.svh"

module pss_top #(
  parameter logic [31:0] MINUTE_CYC =
    32'(64'(`PSS_MINUTE_S) * 64'd1000000000 / 64'(`PSS_CLK_NS)),
  parameter logic [31:0] STEP_CYC =
    32'(`PSS_STEP_US * 1000 / `PSS_CLK_NS)
) (
  input wire logic clk_i, // Core clock, 40 MHz.
  input wire logic reset_n_i, // Asynchronous reset, active low.
  input wire logic ce_i, // Clock enable, freezes all state.
  input wire logic [7:0] avs_address_i, // Avalon byte address.
  input wire logic avs_read_i, // Avalon read.
  input wire logic avs_write_i, // Avalon write.
  input wire logic [3:0] avs_byteenable_i, // Avalon byte enables.
  input wire logic [31:0] avs_writedata_i, // Avalon write data.
  output logic [31:0] avs_readdata_o, // Avalon read data.
  output logic avs_waitrequest_o, // Avalon wait request.
  input wire logic [4:0] term_i, // Virtual input terminals.
  input wire logic run_forward_i, // Forward run command.
  input wire logic run_reverse_i, // Reverse run command.
  input wire logic jog_active_i, // Jog operation in progress.
  input wire logic pid_active_i, // PID operation in progress.
  input wire logic ext24_supply_i, // Running from 24 V external supply.
  input wire logic panel_unit_i, // Panel operation, else network.
  input wire logic [15:0] nvm_rdata_i, // Stored frequency at power-up.
  output logic nvm_wr_o, // Nonvolatile write strobe.
  output logic [15:0] nvm_wdata_o, // Nonvolatile write data.
  output logic [15:0] freq_cmd_o, // Frequency command, 0.1 Hz.
  output logic aux_supply_indicator_o // Auxiliary supply indication.
);

  pss_pkg::pss_state_t s_r;
  pss_pkg::pss_state_t s_nxt;
  logic [15:0] stored;
  logic sel_h;
  logic sel_m;
  logic sel_l;
  logic sel_x;
  logic run;
  logic run_fall;
  logic ev_rise;
  logic remote_on;
  logic inhibit;
  logic save_now;
  logic [15:0] base;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // True when any terminal carrying the given function code is active.
  function automatic logic fn_sel(input logic [19:0] asg,
                                  input logic [4:0] t,
                                  input logic [3:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `PSS_NTERM; i++)
      if (t[i] && asg[i*4 +: 4] == code)
        hit = 1'b1;
    return hit;
  endfunction

  // Merge write data into an old word under the byte enables.
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Decoded inputs, all from the second synchroniser stage
  // ----------------------------------------------------------------------
  // Function assignment routes terminals; ext only exists if code 8 is set.
  assign sel_l = fn_sel(s_r.asg, s_r.sy2[4:0], `PSS_FN_LOW);
  assign sel_m = fn_sel(s_r.asg, s_r.sy2[4:0], `PSS_FN_MID);
  assign sel_h = fn_sel(s_r.asg, s_r.sy2[4:0], `PSS_FN_HIGH);
  assign sel_x = fn_sel(s_r.asg, s_r.sy2[4:0], `PSS_FN_EXT);
  assign run = s_r.sy2[`PSS_P_FWD] | s_r.sy2[`PSS_P_REV];
  assign run_fall = s_r.run_d & ~run;
  assign ev_rise = s_r.sy2[`PSS_P_EV] & ~s_r.ev_d;
  assign remote_on = s_r.mode != `PSS_MODE_PRESET;
  assign inhibit = s_r.sy2[`PSS_P_JOG] | s_r.sy2[`PSS_P_PID];
  assign save_now = run_fall | (ev_rise & run);
  // Base command depends on who operates the drive.
  assign base = s_r.sy2[`PSS_P_PANEL] ? s_r.panel : s_r.net;

  // ----------------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------------
  // Unmapped addresses read as zero.
  function automatic logic [31:0] reg_read(input logic [7:0] a,
                                           input pss_pkg::pss_state_t s,
                                           input logic [15:0] st);
    logic [31:0] r;
    r = '0;
    if (a <= `PSS_A_PRESET_END && a[1:0] == 2'h0)
      r[15:0] = s.pre[a[5:2]];
    else
      case (a)
        `PSS_A_MODE: r[1:0] = s.mode;
        `PSS_A_GUARD: r[0] = s.guard;
        `PSS_A_ASSIGN: r[19:0] = s.asg;
        `PSS_A_NET: r[15:0] = s.net;
        `PSS_A_PANEL: r[15:0] = s.panel;
        `PSS_A_MAX: r[15:0] = s.maxf;
        `PSS_A_STATUS: r[18:0] = {s.run_d, s.mode != `PSS_MODE_PRESET,
                                 s.aux, s.freq};
        `PSS_A_REMOTE: r[15:0] = s.remote;
        `PSS_A_STORED: r[15:0] = st;
        default: r = '0;
      endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Everything advances only while the clock enable is high.
  always_comb
  begin
    logic [31:0] w;
    logic [3:0] ci;
    logic cv;
    logic [15:0] pf;
    w = '0;
    ci = '0;
    cv = 1'b0;
    pf = '0;
    s_nxt = s_r;
    if (ce_i)
    begin
      // Pins are sampled twice before anything looks at them.
      s_nxt.sy1 = {panel_unit_i, ext24_supply_i, pid_active_i, jog_active_i,
                   run_reverse_i, run_forward_i, term_i};
      s_nxt.sy2 = s_r.sy1;
      s_nxt.run_d = run;
      s_nxt.ev_d = s_r.sy2[`PSS_P_EV];

      // Bus handshake: capture, answer one cycle later, then one idle.
      case (s_r.bus)
        pss_pkg::PSS_BUS_IDLE:
        begin
          if (avs_read_i || avs_write_i)
          begin
            s_nxt.bus = pss_pkg::PSS_BUS_ACK;
            s_nxt.wreq = 1'b0;
            s_nxt.rdata = reg_read(avs_address_i, s_r, stored);
          end
        end
        pss_pkg::PSS_BUS_ACK:
        begin
          s_nxt.bus = pss_pkg::PSS_BUS_DONE;
          s_nxt.wreq = 1'b1;
          if (avs_write_i)
          begin
            w = be_merge(reg_read(avs_address_i, s_r, stored),
                         avs_writedata_i, avs_byteenable_i);
            if (avs_address_i <= `PSS_A_PRESET_END &&
                avs_address_i[1:0] == 2'h0)
              s_nxt.pre[avs_address_i[5:2]] = w[15:0];
            else if (avs_address_i == `PSS_A_GUARD)
              s_nxt.guard = w[0];
            else if (avs_address_i == `PSS_A_NET)
              s_nxt.net = w[15:0];
            else if (avs_address_i == `PSS_A_PANEL)
              s_nxt.panel = w[15:0];
            else if (!s_r.guard)
            begin
              if (avs_address_i == `PSS_A_MODE)
                s_nxt.mode = w[1:0];
              else if (avs_address_i == `PSS_A_ASSIGN)
                s_nxt.asg = w[19:0];
              else if (avs_address_i == `PSS_A_MAX)
                s_nxt.maxf = w[15:0];
            end
          end
        end
        pss_pkg::PSS_BUS_DONE: s_nxt.bus = pss_pkg::PSS_BUS_IDLE;
        default:
        begin
          s_nxt.bus = pss_pkg::PSS_BUS_IDLE;
          s_nxt.wreq = 1'b1;
        end
      endcase

      // Preset decode: {ext, high, mid, low} picks one slot, or the base command when none is set.
      case ({sel_x, sel_h, sel_m, sel_l})
        4'b0110: begin ci = `PSS_IDX_SPD4; cv = 1'b1; end
        4'b0101: begin ci = `PSS_IDX_SPD5; cv = 1'b1; end
        4'b0011: begin ci = `PSS_IDX_SPD6; cv = 1'b1; end
        4'b0111: begin ci = `PSS_IDX_SPD7; cv = 1'b1; end
        default:
        begin
          ci = `PSS_IDX_SPD8 + {1'b0, sel_h, sel_m, sel_l};
          cv = sel_x;
        end
      endcase
      if (cv && s_r.pre[ci] != `PSS_SENTINEL)
        pf = s_r.pre[ci];
      else if (sel_x && ci == `PSS_IDX_SPD8)
        pf = s_r.pre[`PSS_IDX_LOW];
      else if (sel_l)
        pf = s_r.pre[`PSS_IDX_LOW];
      else if (sel_m)
        pf = s_r.pre[`PSS_IDX_MID];
      else if (sel_h)
        pf = s_r.pre[`PSS_IDX_HIGH];
      else
        pf = base;

      // Restore waits for a remote mode, as the mode resets to preset.
      if (s_r.restore)
      begin
        s_nxt.restore = s_r.mode == `PSS_MODE_PRESET;
        if (s_r.mode == `PSS_MODE_STORE)
          s_nxt.remote = nvm_rdata_i;
      end
      else if (remote_on && !inhibit)
      begin
        if (sel_l)
        begin
          s_nxt.remote = `PSS_DEF_ZERO;
          s_nxt.step = '0;
        end
        else if (sel_h != sel_m)
        begin
          if (s_r.step >= STEP_CYC - 32'h1)
          begin
            s_nxt.step = '0;
            if (sel_h && s_r.remote < s_r.maxf)
              s_nxt.remote = s_r.remote + `PSS_STEP;
            else if (sel_m && s_r.remote != `PSS_DEF_ZERO)
              s_nxt.remote = s_r.remote - `PSS_STEP;
          end
          else
            s_nxt.step = s_r.step + 32'h1;
        end
        else
          s_nxt.step = '0;
        if (s_r.mode == `PSS_MODE_CLRRUN && run_fall)
          s_nxt.remote = `PSS_DEF_ZERO;
      end
      // A lowered maximum pulls the adjustment down with it.
      if (s_nxt.remote > s_r.maxf)
        s_nxt.remote = s_r.maxf;

      // Indicator latches when the 24 V source takes over mid-run.
      if (ev_rise && run)
        s_nxt.aux = 1'b1;
      else if (!s_r.sy2[`PSS_P_EV])
        s_nxt.aux = 1'b0;

      // Output command; the sum cannot exceed base plus maximum.
      if (!remote_on)
        s_nxt.freq = pf;
      else if (inhibit)
        s_nxt.freq = base;
      else
        s_nxt.freq = base + s_r.remote;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset loads constants only; the stored value is taken after release.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_r <= '0;
      s_r.pre <= {{12{`PSS_SENTINEL}}, `PSS_DEF_LOW, `PSS_DEF_MID,
                  `PSS_DEF_HIGH};
      s_r.asg <= `PSS_ASSIGN_RST;
      s_r.maxf <= `PSS_DEF_MAX;
      s_r.restore <= 1'b1;
      s_r.bus <= pss_pkg::PSS_BUS_IDLE;
      s_r.wreq <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------------
  // Storage scheduler
  // ----------------------------------------------------------------------
  // Saves happen only in the stored remote mode.
  pss_nvm_store #(
    .MINUTE_CYC(MINUTE_CYC)
  ) u_store (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .enable_i(s_r.mode == `PSS_MODE_STORE),
    .idle_i(sel_h == sel_m),
    .save_now_i(save_now),
    .load_i(s_r.restore),
    .load_val_i(nvm_rdata_i),
    .value_i(s_r.remote),
    .nvm_wr_o(nvm_wr_o),
    .nvm_wdata_o(nvm_wdata_o),
    .stored_o(stored)
  );

  assign avs_readdata_o = s_r.rdata;
  assign avs_waitrequest_o = s_r.wreq;
  assign freq_cmd_o = s_r.freq;
  assign aux_supply_indicator_o = s_r.aux;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  preset_high_a: assert property (
    ce_i && !remote_on && sel_h && !sel_m && !sel_l && !sel_x
    |=> freq_cmd_o == $past(s_r.pre[`PSS_IDX_HIGH]))
    else $error("high select did not give high preset");

  mid_wins_a: assert property (
    ce_i && !remote_on && sel_h && sel_m && !sel_l && !sel_x &&
    s_r.pre[`PSS_IDX_SPD4] == `PSS_SENTINEL
    |=> freq_cmd_o == $past(s_r.pre[`PSS_IDX_MID]))
    else $error("mid did not override high");

  ext_fallback_a: assert property (
    ce_i && !remote_on && sel_x && !sel_h && !sel_m && !sel_l &&
    s_r.pre[`PSS_IDX_SPD8] == `PSS_SENTINEL
    |=> freq_cmd_o == $past(s_r.pre[`PSS_IDX_LOW]))
    else $error("unset speed 8 did not fall back to low preset");

  guard_bypass_a: assert property (
    ce_i && s_r.bus == pss_pkg::PSS_BUS_ACK && avs_write_i && s_r.guard &&
    avs_address_i == 8'h00 && avs_byteenable_i == 4'hF
    |=> s_r.pre[`PSS_IDX_HIGH] == $past(avs_writedata_i[15:0]))
    else $error("preset write refused under guard");

  remote_clear_a: assert property (
    ce_i && remote_on && !inhibit && !s_r.restore && sel_l
    |=> s_r.remote == 16'h0000 ##1 !ce_i || freq_cmd_o == $past(base))
    else $error("clear did not zero remote adjustment");

  remote_limit_a: assert property (
    ce_i |=> s_r.remote <= $past(s_r.maxf))
    else $error("remote adjustment exceeds maximum");

  run_off_save_a: assert property (
    ce_i && s_r.mode == `PSS_MODE_STORE && !s_r.restore && run_fall
    |=> nvm_wr_o && nvm_wdata_o == $past(s_r.remote))
    else $error("run off did not save remote frequency");

  aux_show_a: assert property (
    ce_i && ev_rise && run |=> aux_supply_indicator_o)
    else $error("24 V takeover during run not indicated");

  ext_gate_a: assert property (
    sel_x |-> s_r.asg[3:0] == `PSS_FN_EXT || s_r.asg[7:4] == `PSS_FN_EXT ||
    s_r.asg[11:8] == `PSS_FN_EXT || s_r.asg[15:12] == `PSS_FN_EXT ||
    s_r.asg[19:16] == `PSS_FN_EXT)
    else $error("ext select seen without code 8 assigned");

  inhibit_hold_a: assert property (
    ce_i && remote_on && inhibit && !s_r.restore &&
    s_r.remote <= s_r.maxf |=> $stable(s_r.remote))
    else $error("remote adjustment moved during jog or PID");

endmodule
`default_nettype wire

// File: tb/pss_fb_master.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Fieldbus master driving the virtual terminals
// ----------------------------------------------------------------------
module pss_fb_master (
  input wire logic clk_i, // Core clock.
  input wire logic [3:0] sel_i, // Wanted {ext,high,mid,low}.
  input wire logic spare_i, // Level for the unassigned terminal.
  input wire logic run_i, // Wanted forward run.
  output logic [4:0] term_o, // Virtual terminals.
  output logic run_forward_o // Forward run command.
);
  // All terminals move on one edge, so no stray combination is seen.
  always_ff @(posedge clk_i)
  begin
    term_o <= {spare_i, sel_i};
    run_forward_o <= run_i;
  end
endmodule
`default_nettype wire

// File: tb/tb_pss_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pss_top;
  logic clk_i = 0, reset_n_i = 0, rd = 0, wr = 0, run = 0, spare = 0;
  logic ce = 1, jog = 0, pid = 0, ev = 0, pan = 0;
  logic [15:0] rv;
  logic [15:0] nq[$];
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, rdat;
  logic [3:0] sel = 0;
  logic [4:0] term;
  logic runf, nwr, aux, wtr;
  logic [15:0] nwd, frq, v;
  logic [63:0] eq[$];
  int err_total = 0, n_tests = 0, npulse = 0, seed = 84935;
  // ----------------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------------
  pss_top #(.MINUTE_CYC(32'hC8), .STEP_CYC(32'h4)) u_dut (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .ce_i(ce), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hF),
    .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wtr), .term_i(term), .run_forward_i(runf),
    .run_reverse_i(1'b0), .jog_active_i(jog), .pid_active_i(pid),
    .ext24_supply_i(ev), .panel_unit_i(pan), .nvm_rdata_i(v),
    .nvm_wr_o(nwr), .nvm_wdata_o(nwd), .freq_cmd_o(frq),
    .aux_supply_indicator_o(aux));
  pss_fb_master u_fb (.clk_i(clk_i), .sel_i(sel), .spare_i(spare),
    .run_i(run), .term_o(term), .run_forward_o(runf));
  // Free running clock, 25 ns period.
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  // One bus access; reads leave their expectation in the queue.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] m);
    @(posedge clk_i);
    adr <= a;
    wd <= w ? d : 32'h0;
    wr <= w;
    rd <= !w;
    if (!w)
      eq.push_back({m, d});
    do @(posedge clk_i); while (wtr !== 1'b0);
    wr <= 0;
    rd <= 0;
  endtask
  // Sets a select pattern, lets it pass the synchroniser, reads status.
  task pick(input logic [3:0] s, input logic [15:0] f);
    @(posedge clk_i);
    sel <= s;
    spare <= 1'($random(seed));
    repeat (6) @(posedge clk_i);
    n_tests++;
    if (frq !== f)
    begin
      err_total++;
      $display("[FAIL] %0t frequency pin %h, want %h", $time, frq, f);
    end
    bus(0, 8'h58, {16'h0, f}, 32'h0000FFFF);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Takes the oldest expectation whenever read data is handed over.
  always @(posedge clk_i)
  begin
    if (rd && wtr === 1'b0)
    begin
      logic [63:0] e;
      e = eq.pop_front();
      n_tests++;
      if ((rdat & e[63:32]) !== e[31:0])
      begin
        err_total++;
        $display("[FAIL] %0t read %h at %h", $time, rdat, adr);
      end
    end
    // Every write strobe must carry the oldest expected stored value.
    if (nwr === 1'b1)
    begin
      npulse++;
      n_tests++;
      if (nq.size() == 0 || nwd !== nq.pop_front())
      begin
        err_total++;
        $display("[FAIL] %0t unexpected stored value %h", $time, nwd);
      end
    end
  end
  // Watchdog against a hung handshake.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    v <= 16'($random(seed));
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1;
    bus(0, 8'h00, 32'h258, 32'hFFFF);
    bus(0, 8'h0C, 32'h270F, 32'hFFFF);
    bus(0, 8'h48, 32'hFF210, 32'hFFFFF);
    bus(0, 8'h7C, 32'h0, 32'hFFFFFFFF);
    $display("reset values done");
    pick(4'b0100, 16'h258);
    pick(4'b0110, 16'h12C);
    pick(4'b0111, 16'h064);
    pick(4'b1000, 16'h000);
    $display("three speeds done");
    bus(1, 8'h48, 32'hF8210, 0);
    pick(4'b1000, 16'h064);
    bus(1, 8'h1C, 32'h1F4, 0);
    pick(4'b1000, 16'h1F4);
    pick(4'b1001, 16'h064);
    $display("extended speeds done");
    v <= 16'(16'h0001 + $unsigned($random(seed)) % 4000);
    bus(1, 8'h44, 32'h1, 0);
    bus(1, 8'h40, 32'h1, 0);
    bus(0, 8'h40, 32'h0, 32'h3);
    bus(1, 8'h00, {16'h0, v}, 0);
    pick(4'b0100, v);
    $display("write guard done");
    bus(1, 8'h44, 32'h0, 0);
    bus(1, 8'h4C, 32'h100, 0);
    bus(1, 8'h40, 32'h1, 0);
    // The stored value comes back, limited to the reset maximum.
    rv = (v > 16'h04B0) ? 16'h04B0 : v;
    pick(4'b0000, 16'h0100 + rv);
    bus(1, 8'h50, 32'h80, 0);
    pan <= 1;
    pick(4'b0000, 16'h0080 + rv);
    pan <= 0;
    jog <= 1;
    pick(4'b0000, 16'h0100);
    jog <= 0;
    pid <= 1;
    pick(4'b0000, 16'h0100);
    pid <= 0;
    nq.push_back(rv);
    nq.push_back(rv);
    run <= 1;
    repeat (8) @(posedge clk_i);
    ev <= 1;
    repeat (6) @(posedge clk_i);
    n_tests++;
    if (aux !== 1'b1)
    begin
      err_total++;
      $display("[FAIL] %0t auxiliary supply not shown", $time);
    end
    run <= 0;
    repeat (8) @(posedge clk_i);
    n_tests++;
    if (npulse !== 2)
    begin
      err_total++;
      $display("[FAIL] %0t store pulses %0d", $time, npulse);
    end
    $display("remote store done");
    nq.push_back(16'h0000);
    pick(4'b0001, 16'h0100);
    repeat (250) @(posedge clk_i);
    n_tests++;
    if (npulse !== 3 || nq.size() != 0)
    begin
      err_total++;
      $display("[FAIL] %0t minute store pulses %0d", $time, npulse);
    end
    $display("minute store done");
    give_verdict();
  end
endmodule
`default_nettype wire
